// ---- rtl/cpv_pkg.sv ----
// shared constants, register map and carrier types of the cell pack voltage alarm block
package cpv_pkg;

    // time base and delay figures
    localparam int unsigned CLK_FREQ_HZ      = 250_000_000;                  // core clock rate
    localparam int unsigned DETECT_DELAY_MS  = 128;                          // detect_delay of this variant
    localparam int unsigned RELEASE_DELAY_MS = 8;                            // release_delay of this variant
    localparam int unsigned DETECT_CYCLES    = DETECT_DELAY_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned RELEASE_CYCLES   = RELEASE_DELAY_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned CNT_W            = 32;                           // delay counter width

    localparam int unsigned CELLS_MAX        = 6;                            // widest pack supported
    localparam int unsigned STEP_W           = 5;                            // self-test step counter width
    localparam logic [4:0]  STEP_REG_HIGH    = 5'h0E;                        // regulator high fault pulse
    localparam logic [4:0]  STEP_REG_LOW     = 5'h0F;                        // regulator low fault pulse

    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h0C;

    // control register fields
    localparam int unsigned CTRL_ACTIVE_LOW  = 0;                            // alarm polarity
    localparam int unsigned CTRL_OPEN_DRAIN  = 1;                            // alarm drive form
    localparam int unsigned CTRL_SEPARATE    = 2;                            // overdischarge routing
    localparam int unsigned CTRL_LATCH       = 3;                            // self-test result latch
    localparam int unsigned CTRL_W           = 4;
    localparam logic [3:0]  CTRL_RESET       = 4'h0;

    // interrupt bits
    localparam int unsigned IRQ_OC_SET       = 0;
    localparam int unsigned IRQ_OD_SET       = 1;
    localparam int unsigned IRQ_OC_CLR       = 2;
    localparam int unsigned IRQ_OD_CLR       = 3;
    localparam int unsigned IRQ_FAIL         = 4;
    localparam int unsigned IRQ_W            = 5;
    localparam logic [4:0]  IRQ_MASK_RESET   = 5'h00;

    // self-test pulse kinds
    typedef enum logic [2:0] {
        CPV_PULSE_NONE,
        CPV_PULSE_OC,
        CPV_PULSE_OD,
        CPV_PULSE_REG_HI,
        CPV_PULSE_REG_LO
    } cpv_pulse_t;

    // all asynchronous pin inputs, carried together through the synchroniser
    typedef struct packed {
        logic [CELLS_MAX-1:0] oc_trip;                                       // cell above overcharge_trip_level
        logic [CELLS_MAX-1:0] oc_clear;                                      // cell below overcharge_clear_level
        logic [CELLS_MAX-1:0] od_trip;                                       // cell below overdischarge_trip_level
        logic [CELLS_MAX-1:0] od_clear;                                      // cell above overdischarge_clear_level
        logic                 cell_count_select_a;
        logic                 cell_count_select_b;
        logic                 self_test_request;
        logic                 step;
        logic                 reg_high_det;                                  // regulator high fault detector
        logic                 reg_low_det;                                   // regulator low fault detector
    } cpv_pins_t;

    typedef struct packed {
        cpv_pins_t stage1;                                                   // first flop, read only by stage2
        cpv_pins_t stage2;
    } cpv_sync_state_t;

    typedef struct packed {
        logic             active;                                            // qualified state
        logic [CNT_W-1:0] cnt;                                               // uninterrupted cycles so far
    } cpv_qual_state_t;

endpackage

// ---- rtl/cpv_sync.sv ----
// two flip-flop synchroniser for all pin inputs
`timescale 1ns/1ns
module cpv_sync
    import cpv_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire cpv_pins_t d_i,
    output cpv_pins_t      q_o
);
    cpv_sync_state_t s;      // registered state
    cpv_sync_state_t next_s; // next state

    // stage1 feeds stage2 only; nothing else looks at it
    always_comb begin
        next_s        = s;
        next_s.stage1 = d_i;
        next_s.stage2 = s.stage1;
    end

    // register the copy; zero at reset means all comparators idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.stage2;
endmodule

// ---- rtl/cpv_qual.sv ----
// detect/release delay qualifier: a state set and cleared only by uninterrupted conditions
`timescale 1ns/1ns
module cpv_qual
    import cpv_pkg::*;
#(
    parameter logic [CNT_W-1:0] DET_CYCLES = CNT_W'(DETECT_CYCLES),
    parameter logic [CNT_W-1:0] REL_CYCLES = CNT_W'(RELEASE_CYCLES)
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic detect_i,  // detection condition holds this cycle
    input  wire logic release_i, // release condition holds this cycle
    output logic      active_o   // qualified state
);
    cpv_qual_state_t s;      // registered state
    cpv_qual_state_t next_s; // next state

    // counting on the core clock as time base keeps one timer per state
    always_comb begin
        next_s = s;
        if (!s.active) begin
            if (!detect_i) begin
                next_s.cnt = '0;                              // lapse restarts the wait
            end else if (s.cnt >= DET_CYCLES - 1'b1) begin
                next_s.active = 1'b1;
                next_s.cnt    = '0;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end else begin
            if (!release_i) begin
                next_s.cnt = '0;                              // lapse restarts the wait
            end else if (s.cnt >= REL_CYCLES - 1'b1) begin
                next_s.active = 1'b0;
                next_s.cnt    = '0;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    // register the copy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign active_o = s.active;
endmodule

// ---- rtl/cpv_top.sv ----
// cell pack voltage alarm logic with wishbone registers and interrupt
`timescale 1ns/1ns
module cpv_top
    import cpv_pkg::*;
#(
    parameter logic [CNT_W-1:0] DET_CYCLES = CNT_W'(DETECT_CYCLES),  // detect_delay in clocks
    parameter logic [CNT_W-1:0] REL_CYCLES = CNT_W'(RELEASE_CYCLES)  // release_delay in clocks
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      irq_o,
    // comparator results per cell
    input  wire logic [CELLS_MAX-1:0] oc_trip_i,
    input  wire logic [CELLS_MAX-1:0] oc_clear_i,
    input  wire logic [CELLS_MAX-1:0] od_trip_i,
    input  wire logic [CELLS_MAX-1:0] od_clear_i,
    // pins from the board and host
    input  wire logic                 cell_count_select_a_i,
    input  wire logic                 cell_count_select_b_i,
    input  wire logic                 self_test_request_i,
    input  wire logic                 step_i,
    input  wire logic                 reg_high_det_i,
    input  wire logic                 reg_low_det_i,
    // alarm pins
    output logic                      primary_alarm_output_o,
    output logic                      primary_alarm_output_oe_o,
    output logic                      secondary_alarm_output_o,
    output logic                      secondary_alarm_output_oe_o
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;      // option bits
        logic [IRQ_W-1:0]  irq_stat;  // sticky events
        logic [IRQ_W-1:0]  irq_mask;  // interrupt enables
        logic              ack;       // bus answer
        logic [31:0]       rdata;     // read data
        logic              oc_prev;   // last overcharge state
        logic              od_prev;   // last overdischarge state
        logic              req_prev;  // last request level
        logic              step_prev; // last step level
        logic [STEP_W-1:0] step_cnt;  // step pulses since request rose
        logic              seen;      // current pulse showed detection
        logic              fail;      // self-test failure found
        logic              pending;   // power-up detection awaiting request pulse
        logic              pri_out;
        logic              pri_oe;
        logic              sec_out;
        logic              sec_oe;
    } cpv_top_state_t;

    cpv_top_state_t       s;          // registered state
    cpv_top_state_t       next_s;     // next state
    cpv_pins_t            pins_raw;   // pins before synchroniser
    cpv_pins_t            pins;       // synchronised pins
    logic [CELLS_MAX-1:0] cell_mask;  // monitored cells
    logic [CELLS_MAX-1:0] force_oc;   // self-test overcharge stimulus
    logic [CELLS_MAX-1:0] force_od;   // self-test overdischarge stimulus
    logic [CELLS_MAX-1:0] eff_oc_trip;
    logic [CELLS_MAX-1:0] eff_oc_clear;
    logic [CELLS_MAX-1:0] eff_od_trip;
    logic [CELLS_MAX-1:0] eff_od_clear;
    logic                 oc_active;  // qualified overcharge state
    logic                 od_active;  // qualified overdischarge state
    logic                 testing;    // self-test running
    logic                 pulse_hi;   // step pulse high in self-test
    cpv_pulse_t           kind;       // what the current pulse exercises
    logic [2:0]           pulse_cell; // cell index exercised

    // select pins to monitored cell mask
    function automatic logic [CELLS_MAX-1:0] cells_of(input logic sel_a, input logic sel_b);
        case ({sel_a, sel_b})
            2'b00:   cells_of = 6'h3F;                              // six cells
            2'b01:   cells_of = 6'h1F;                              // five cells
            2'b10:   cells_of = 6'h0F;                              // four cells
            default: cells_of = 6'h07;                              // three cells
        endcase
    endfunction

    // number of cells from the mask
    function automatic logic [4:0] count_of(input logic [CELLS_MAX-1:0] mask);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < CELLS_MAX; i++) begin
            n = n + {4'h0, mask[i]};
        end
        count_of = n;
    endfunction

    // one alarm pin: detection level under polarity, then drive form
    function automatic logic [1:0] pin_of(input logic detect, input logic act_low, input logic od);
        logic lvl;
        lvl = detect ^ act_low;                                     // asserted level follows polarity
        if (od) begin
            pin_of = {1'b0, ~lvl};                                  // open drain pulls low only
        end else begin
            pin_of = {lvl, 1'b1};                                   // push-pull drives always
        end
    endfunction

    assign pins_raw = '{oc_trip: oc_trip_i, oc_clear: oc_clear_i, od_trip: od_trip_i, od_clear: od_clear_i,
                        cell_count_select_a: cell_count_select_a_i, cell_count_select_b: cell_count_select_b_i,
                        self_test_request: self_test_request_i, step: step_i,
                        reg_high_det: reg_high_det_i, reg_low_det: reg_low_det_i};

    cpv_sync u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pins_raw),
        .q_o   (pins)
    );

    // decode which check the current step pulse performs
    always_comb begin
        cell_mask  = cells_of(pins.cell_count_select_a, pins.cell_count_select_b);
        testing    = pins.self_test_request;
        pulse_hi   = testing && pins.step;
        kind       = CPV_PULSE_NONE;
        pulse_cell = 3'h0;
        force_oc   = '0;
        force_od   = '0;
        if (s.step_cnt != 5'h00 && {1'b0, s.step_cnt} <= {count_of(cell_mask), 1'b0}) begin
            kind       = s.step_cnt[0] ? CPV_PULSE_OC : CPV_PULSE_OD;       // odd/even pulse
            pulse_cell = 3'(((s.step_cnt + 5'h01) >> 1) - 5'h01);
        end else if (s.step_cnt == STEP_REG_HIGH) begin
            kind = CPV_PULSE_REG_HI;
        end else if (s.step_cnt == STEP_REG_LOW) begin
            kind = CPV_PULSE_REG_LO;
        end
        // the stimulus shifts the comparator inputs of one cell while the pulse is high
        if (pulse_hi && kind == CPV_PULSE_OC) begin
            force_oc[pulse_cell] = 1'b1;
        end
        if (pulse_hi && kind == CPV_PULSE_OD) begin
            force_od[pulse_cell] = 1'b1;
        end
        eff_oc_trip  = (pins.oc_trip | force_oc) & cell_mask;
        eff_oc_clear = pins.oc_clear & ~force_oc;
        eff_od_trip  = (pins.od_trip | force_od) & cell_mask;
        eff_od_clear = pins.od_clear & ~force_od;
    end

    // overcharge: any monitored cell above trip to set, every monitored cell below clear to release
    cpv_qual #(
        .DET_CYCLES (DET_CYCLES),
        .REL_CYCLES (REL_CYCLES)
    ) u_oc (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .detect_i  (|eff_oc_trip),
        .release_i (&(eff_oc_clear | ~cell_mask)),
        .active_o  (oc_active)
    );

    // overdischarge: any monitored cell below trip to set, every monitored cell above clear to release
    cpv_qual #(
        .DET_CYCLES (DET_CYCLES),
        .REL_CYCLES (REL_CYCLES)
    ) u_od (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .detect_i  (|eff_od_trip),
        .release_i (&(eff_od_clear | ~cell_mask)),
        .active_o  (od_active)
    );

    // self-test sequencing, alarm pins, registers and interrupt events
    always_comb begin
        logic             pri_det;
        logic             sec_det;
        logic             reg_show;
        logic             sep;
        logic [IRQ_W-1:0] ev;
        logic [1:0]       pin;
        logic             acc;
        pri_det = 1'b0;
        sec_det = 1'b0;
        reg_show = 1'b0;
        sep = s.ctrl[CTRL_SEPARATE];
        ev = '0;
        pin = 2'b00;
        acc = wb_cyc_i && wb_stb_i && !s.ack;
        next_s = s;

        // request edges: rise starts a fresh run, fall ends it
        next_s.req_prev  = testing;
        next_s.step_prev = pins.step;
        if (testing && !s.req_prev) begin
            next_s.step_cnt = '0;
            next_s.fail     = 1'b0;
            next_s.seen     = 1'b0;
        end
        if (!testing && s.req_prev) begin
            next_s.pending = 1'b0;                                          // request pulse clears
            next_s.step_cnt = '0;
        end
        if (pulse_hi) begin
            case (kind)
                CPV_PULSE_OC:     next_s.seen = s.seen | oc_active;
                CPV_PULSE_OD:     next_s.seen = s.seen | od_active;
                CPV_PULSE_REG_HI: next_s.seen = s.seen | pins.reg_high_det;
                CPV_PULSE_REG_LO: next_s.seen = s.seen | pins.reg_low_det;
                default:          next_s.seen = s.seen;
            endcase
        end
        // step rise advances the check and must win over the stale seen of the last pulse; fall judges it
        if (testing && pins.step && !s.step_prev && s.step_cnt != 5'h1F) begin
            next_s.step_cnt = s.step_cnt + 5'h01;
            next_s.seen     = 1'b0;
        end
        if (testing && !pins.step && s.step_prev && kind != CPV_PULSE_NONE && !s.seen) begin
            next_s.fail = 1'b1;
            ev[IRQ_FAIL] = 1'b1;
        end

        // regulator status shown on secondary while its pulse is high
        if (pulse_hi && kind == CPV_PULSE_REG_HI) begin
            reg_show = pins.reg_high_det;
        end
        if (pulse_hi && kind == CPV_PULSE_REG_LO) begin
            reg_show = pins.reg_low_det;
        end

        // alarm routing; outside self-test, with nothing active and no power-up flag pending both pins deassert
        pri_det = oc_active || (od_active && !sep);
        if (testing) begin
            // in self-test overcharge shows on both pins, overdischarge on secondary in either type
            sec_det = oc_active || od_active || reg_show ||
                      (s.fail && s.ctrl[CTRL_LATCH]);
        end else begin
            sec_det = (od_active && sep) || s.pending;
        end
        pin            = pin_of(pri_det, s.ctrl[CTRL_ACTIVE_LOW], s.ctrl[CTRL_OPEN_DRAIN]);
        next_s.pri_out = pin[1];
        next_s.pri_oe  = pin[0];
        pin            = pin_of(sec_det, s.ctrl[CTRL_ACTIVE_LOW], s.ctrl[CTRL_OPEN_DRAIN]);
        next_s.sec_out = pin[1];
        next_s.sec_oe  = pin[0];

        // state change events
        next_s.oc_prev = oc_active;
        next_s.od_prev = od_active;
        ev[IRQ_OC_SET] = oc_active && !s.oc_prev;
        ev[IRQ_OD_SET] = od_active && !s.od_prev;
        ev[IRQ_OC_CLR] = !oc_active && s.oc_prev;
        ev[IRQ_OD_CLR] = !od_active && s.od_prev;

        // wishbone: answer one cycle after the request, drop ack the cycle after
        next_s.ack   = acc;
        next_s.rdata = 32'h0000_0000;
        if (acc && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_CTRL:     next_s.ctrl     = wb_dat_i[CTRL_W-1:0];
                ADDR_IRQ_MASK: next_s.irq_mask = wb_dat_i[IRQ_W-1:0];
                default:       next_s.ctrl     = s.ctrl;                    // others ignore writes
            endcase
        end
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL:       next_s.rdata = {28'h0000000, s.ctrl};
                ADDR_STATUS:     next_s.rdata = {8'h00, 3'h0, s.step_cnt, 3'h0, count_of(cell_mask),
                                                 3'h0, s.pending, s.fail, testing, od_active, oc_active};
                ADDR_IRQ_STATUS: next_s.rdata = {27'h0000000, s.irq_stat};
                ADDR_IRQ_MASK:   next_s.rdata = {27'h0000000, s.irq_mask};
                default:         next_s.rdata = 32'h0000_0000;              // unmapped reads zero
            endcase
        end
        // read clears, but an event in the same cycle still lands
        if (acc && !wb_we_i && wb_adr_i == ADDR_IRQ_STATUS) begin
            next_s.irq_stat = ev;
        end else begin
            next_s.irq_stat = s.irq_stat | ev;
        end
    end

    // register the copy; pending starts set so a fresh power-up flags the secondary pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.ctrl     <= CTRL_RESET;
            s.irq_mask <= IRQ_MASK_RESET;
            s.pending  <= 1'b1;
            s.pri_oe   <= 1'b1;
            s.sec_oe   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o                    = s.rdata;
    assign wb_ack_o                    = s.ack;
    assign irq_o                       = |(s.irq_stat & s.irq_mask);
    assign primary_alarm_output_o      = s.pri_out;
    assign primary_alarm_output_oe_o   = s.pri_oe;
    assign secondary_alarm_output_o    = s.sec_out;
    assign secondary_alarm_output_oe_o = s.sec_oe;
endmodule

// ---- sim/cpv_cells.sv ----
// behavioural pack of six cells feeding the comparator inputs
`timescale 1ns/1ns
module cpv_cells (
    input  wire logic [5:0] hi_i,       // cells driven above the overcharge trip level
    input  wire logic [5:0] lo_i,       // cells driven below the overdischarge trip level
    output logic      [5:0] oc_trip_o,
    output logic      [5:0] oc_clear_o,
    output logic      [5:0] od_trip_o,
    output logic      [5:0] od_clear_o
);
    // a far-out cell flips both of its comparators, so no half state is ever seen
    assign oc_trip_o  = hi_i;
    assign oc_clear_o = ~hi_i;
    assign od_trip_o  = lo_i;
    assign od_clear_o = ~lo_i;
endmodule

// ---- sim/cpv_top_asserts.sv ----
// checker for alarm timing, drive form and bus handshake
`timescale 1ns/1ns
module cpv_top_asserts import cpv_pkg::*; #(
    parameter int DET_CYCLES = 20,
    parameter int REL_CYCLES = 5
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [5:0]  oc_trip_i,
    input wire logic [5:0]  od_trip_i,
    input wire logic        self_test_request_i,
    input wire logic        primary_alarm_output_o,
    input wire logic        primary_alarm_output_oe_o,
    input wire logic        secondary_alarm_output_o,
    input wire logic        secondary_alarm_output_oe_o
);
    logic [3:0] ctl;                    // mirror of the control register
    logic [7:0] oc_n, od_n, ok_n;       // run lengths, saturating so they never wrap
    wire        idle = !self_test_request_i;
    // detection state read back from each pin under the mirrored options
    wire pri = (ctl[1] ? !primary_alarm_output_oe_o : primary_alarm_output_o) ^ ctl[0];
    wire sec = (ctl[1] ? !secondary_alarm_output_oe_o : secondary_alarm_output_o) ^ ctl[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // mirror lands with the ack edge, the same edge the pins take the new option
    always_ff @(posedge clk_i) begin
        ctl  <= rst_i ? 4'h0 : (wb_ack_o && wb_we_i && wb_adr_i == ADDR_CTRL) ? wb_dat_i[3:0] : ctl;
        oc_n <= (oc_trip_i[0] && idle && !rst_i) ? oc_n + 8'(oc_n != 8'hFF) : 8'h00;
        od_n <= (od_trip_i[0] && idle && !rst_i) ? od_n + 8'(od_n != 8'hFF) : 8'h00;
        ok_n <= (oc_trip_i == 6'h00 && od_trip_i == 6'h00 && idle && !rst_i) ? ok_n + 8'(ok_n != 8'hFF) : 8'h00;
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    a_pri_form: assert property (primary_alarm_output_o |-> primary_alarm_output_oe_o)
        else $error("primary driven high while released");
    a_sec_form: assert property (secondary_alarm_output_o |-> secondary_alarm_output_oe_o)
        else $error("secondary driven high while released");
    a_push_pull: assert property (!ctl[1] |-> primary_alarm_output_oe_o && secondary_alarm_output_oe_o)
        else $error("push-pull pin not driven");
    a_oc_detect: assert property (oc_n == 8'(DET_CYCLES + 5) |-> pri)
        else $error("primary alarm missing after sustained overcharge");
    a_od_route: assert property (od_n == 8'(DET_CYCLES + 5) |-> (ctl[2] ? sec : pri))
        else $error("overdischarge alarm missing on routed pin");
    a_all_release: assert property (ok_n == 8'(REL_CYCLES + 5) && !ctl[2] |-> !pri)
        else $error("primary alarm held after release delay");
endmodule
bind cpv_top cpv_top_asserts #(.DET_CYCLES(DET_CYCLES), .REL_CYCLES(REL_CYCLES)) i_cpv_top_asserts (.*);

// ---- sim/cpv_top_tb.sv ----
// self-checking bench of the alarm block
`timescale 1ns/1ns
module cpv_top_tb import cpv_pkg::*;;
    localparam int DET = 20;            // shortened detect_delay
    localparam int REL = 5;             // shortened release_delay
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, req = 0, step = 0, rl = 0, sa = 0, sb = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, rdat;
    logic [5:0]  hi = 6'h00, lo = 6'h00, oct, occ, odt, odc;
    logic        ack, irq, po, poe, so, soe;
    int          err_total = 0, comparisons = 0;
    always #2 clk = ~clk;
    cpv_cells i_cpv_cells (.hi_i(hi), .lo_i(lo), .oc_trip_o(oct), .oc_clear_o(occ), .od_trip_o(odt), .od_clear_o(odc));
    cpv_top #(.DET_CYCLES(32'(DET)), .REL_CYCLES(32'(REL))) i_cpv_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .oc_trip_i(oct), .oc_clear_i(occ), .od_trip_i(odt), .od_clear_i(odc),
        .cell_count_select_a_i(sa), .cell_count_select_b_i(sb), .self_test_request_i(req), .step_i(step),
        .reg_high_det_i(rl), .reg_low_det_i(rl), .primary_alarm_output_o(po), .primary_alarm_output_oe_o(poe),
        .secondary_alarm_output_o(so), .secondary_alarm_output_oe_o(soe));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one classic cycle; only the watchdog ends a wait for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    // both alarm pins for control value c and the given detection states
    task automatic pins(input logic [3:0] c, input logic dp, input logic ds);
        chk("primary", {po, poe}, c[1] ? {1'b0, !(dp ^ c[0])} : {dp ^ c[0], 1'b1});
        chk("secondary", {so, soe}, c[1] ? {1'b0, !(ds ^ c[0])} : {ds ^ c[0], 1'b1});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        tick(3);
        rst <= 1'b0;
        tick(3);
        pins(4'h0, 1'b0, 1'b1);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
        // a one-cycle lapse just before expiry must restart the count
        hi <= 6'h01;
        tick(DET - 2);
        hi <= 6'h00;
        tick(1);
        hi <= 6'h01;
        tick(DET - 2);
        pins(4'h0, 1'b0, 1'b1);
        tick(10);
        pins(4'h0, 1'b1, 1'b1);
        chk("irq", irq, 32'h1);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk("irq_status", rd, 32'h1);
        chk("irq", irq, 32'h0);
        hi <= 6'h00;
        tick(REL + 6);
        pins(4'h0, 1'b0, 1'b1);
        $display("end overcharge");
        // self-test, separate routing with latch; pulse 14 sees no regulator fault
        bus(1'b1, ADDR_CTRL, 32'hC);
        req <= 1'b1;
        tick(8);
        for (int k = 1; k < 16; k++) begin
            {rl, step} <= {k == 15, 1'b1};
            tick(DET + 10);
            pins(4'hC, k < 13 && k[0], k < 13 || k == 15);
            step <= 1'b0;
            tick(DET + 10);
        end
        pins(4'hC, 1'b0, 1'b1);
        req <= 1'b0;
        tick(8);
        pins(4'hC, 1'b0, 1'b0);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk("irq_status", rd, 32'h1F);
        $display("end self-test");
        // every polarity, drive form and routing option
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, ADDR_CTRL, 32'(c));
            tick(2);
            pins(4'(c), 1'b0, 1'b0);
            lo <= 6'h01;
            tick(DET + 6);
            pins(4'(c), !c[2], c[2]);
            lo <= 6'h00;
            tick(REL + 6);
        end
        chk("irq", irq, 32'h0);
        $display("end options");
        // cell above the selected count is ignored, the top selected cell is not
        for (int s = 0; s < 4; s++) begin
            {sa, sb} <= 2'(s);
            hi <= 6'h01 << (6 - s);
            tick(DET + 6);
            pins(4'h7, 1'b0, 1'b0);
            hi <= 6'h01 << (5 - s);
            tick(DET + 6);
            pins(4'h7, 1'b1, 1'b0);
            hi <= 6'h00;
            tick(REL + 6);
        end
        $display("end cell count");
        wrap_up();
    end
    // the whole run needs about 1600 cycles
    initial begin
        tick(6000);
        err_total++;
        wrap_up();
    end
endmodule
